// *** sensor_event_interrupt_logic.sv ***
// Event flags, masks and open-drain alert pin with an APB register slave
//
// Summary of operation
// - Alert pin driven only with output enable set
// - Alert condition is mask AND flags
// - Alert asserted while any masked flag is one
// - Writing one to a flag clears it
// - Channel one mask gates its flag setting
// - Channel two mask gates its flag setting
// - Channel three mask gates its flag setting
// - Ambient mask 01 sets ambient flag
// - Mode registers and mask decide flag setting
// - Alert pin active low, pulled low
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module sensor_event_interrupt_logic (
  input  wire logic        clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Sample completions from the measurement sequencer
  input  wire logic        prox_one_done,
  input  wire logic        prox_two_done,
  input  wire logic        prox_three_done,
  input  wire logic        ambient_done,
  // Open-drain alert pin, active low
  output logic             alert_n_out,
  output logic             alert_n_oe,
  // System interrupt
  output logic             irq
);
  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] interrupt_config;
  logic [7:0] event_mask;
  logic [7:0] event_mode_a;
  logic [7:0] event_mode_b;
  logic [event_irq_pkg::SYS_WIDTH-1:0] sys_status;
  logic [event_irq_pkg::SYS_WIDTH-1:0] sys_enable;

  flag_bank_if #(.WIDTH(event_irq_pkg::FLAG_WIDTH)) flag_bus ();

  sticky_flag_bank #(
    .WIDTH       (event_irq_pkg::FLAG_WIDTH),
    .RESET_VALUE (event_irq_pkg::RESET_FLAGS)
  ) u_flags (
    .clk     (clk),
    .reset_n (reset_n),
    .port    (flag_bus.bank)
  );

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic [9:0] reg_index;
  logic       setup_phase;
  logic       access_done;
  logic       wr_done;
  logic       addr_hit;

  assign reg_index   = paddr[11:2];
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_done     = access_done && pwrite && !pslverr;

  always_comb begin
    case (reg_index)
      event_irq_pkg::IDX_INTERRUPT_CONFIG,
      event_irq_pkg::IDX_EVENT_MASK,
      event_irq_pkg::IDX_EVENT_MODE_A,
      event_irq_pkg::IDX_EVENT_MODE_B,
      event_irq_pkg::IDX_EVENT_FLAGS,
      event_irq_pkg::IDX_SYS_STATUS,
      event_irq_pkg::IDX_SYS_CLEAR,
      event_irq_pkg::IDX_SYS_ENABLE: addr_hit = 1'b1;
      default:                       addr_hit = 1'b0;
    endcase
  end

  // Zero wait state: answer rises the cycle after setup, falls after access
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !addr_hit;
    end
  end

  // Read data captured at setup so the access phase sees a stable word
  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (reg_index)
      event_irq_pkg::IDX_INTERRUPT_CONFIG: next_prdata[7:0] = interrupt_config;
      event_irq_pkg::IDX_EVENT_MASK:       next_prdata[7:0] = event_mask;
      event_irq_pkg::IDX_EVENT_MODE_A:     next_prdata[7:0] = event_mode_a;
      event_irq_pkg::IDX_EVENT_MODE_B:     next_prdata[7:0] = event_mode_b;
      event_irq_pkg::IDX_EVENT_FLAGS:
        next_prdata[event_irq_pkg::FLAG_WIDTH-1:0] = flag_bus.flags;
      event_irq_pkg::IDX_SYS_STATUS:
        next_prdata[event_irq_pkg::SYS_WIDTH-1:0] = sys_status;
      event_irq_pkg::IDX_SYS_ENABLE:
        next_prdata[event_irq_pkg::SYS_WIDTH-1:0] = sys_enable;
      default:                             next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      interrupt_config <= event_irq_pkg::RESET_REG8;
    end else if (wr_done && reg_index == event_irq_pkg::IDX_INTERRUPT_CONFIG) begin
      interrupt_config <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      event_mask <= event_irq_pkg::RESET_REG8;
    end else if (wr_done && reg_index == event_irq_pkg::IDX_EVENT_MASK) begin
      event_mask <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      event_mode_a <= event_irq_pkg::RESET_REG8;
      event_mode_b <= event_irq_pkg::RESET_REG8;
    end else if (wr_done) begin
      if (reg_index == event_irq_pkg::IDX_EVENT_MODE_A) begin
        event_mode_a <= pwdata[7:0];
      end
      if (reg_index == event_irq_pkg::IDX_EVENT_MODE_B) begin
        event_mode_b <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Flag setting
  // ----------------------------------------------------------------------
  logic [1:0] mode_ambient;
  logic [1:0] mode_prox_one;
  logic [1:0] mode_prox_two;
  logic [1:0] mode_prox_three;
  logic [1:0] ambient_mask;
  logic       prox_one_mask;
  logic       prox_two_mask;
  logic       prox_three_mask;
  logic [event_irq_pkg::FLAG_WIDTH-1:0] next_set;

  assign mode_ambient    = event_mode_a[event_irq_pkg::POS_MODE_AMBIENT +: 2];
  assign mode_prox_one   = event_mode_a[event_irq_pkg::POS_MODE_PROX_ONE +: 2];
  assign mode_prox_two   = event_mode_a[event_irq_pkg::POS_MODE_PROX_TWO +: 2];
  assign mode_prox_three = event_mode_b[event_irq_pkg::POS_MODE_PROX_THREE +: 2];
  assign ambient_mask    = event_mask[event_irq_pkg::POS_AMBIENT_HI:
                                      event_irq_pkg::POS_AMBIENT_LO];
  assign prox_one_mask   = event_mask[event_irq_pkg::POS_PROX_ONE];
  assign prox_two_mask   = event_mask[event_irq_pkg::POS_PROX_TWO];
  assign prox_three_mask = event_mask[event_irq_pkg::POS_PROX_THREE];

  // Threshold modes are outside this block, so a non-zero mode sets nothing
  always_comb begin
    next_set = '0;
    next_set[event_irq_pkg::POS_PROX_ONE] = prox_one_done && prox_one_mask
      && mode_prox_one == event_irq_pkg::MODE_EVERY_SAMPLE;
    next_set[event_irq_pkg::POS_PROX_TWO] = prox_two_done && prox_two_mask
      && mode_prox_two == event_irq_pkg::MODE_EVERY_SAMPLE;
    next_set[event_irq_pkg::POS_PROX_THREE] = prox_three_done && prox_three_mask
      && mode_prox_three == event_irq_pkg::MODE_EVERY_SAMPLE;
    next_set[event_irq_pkg::POS_AMBIENT_LO] = ambient_done
      && ambient_mask == event_irq_pkg::AMBIENT_EVERY_SAMPLE
      && mode_ambient == event_irq_pkg::MODE_EVERY_SAMPLE;
  end

  assign flag_bus.set = next_set;

  // Write one to clear; the written word is masked to the flag width
  assign flag_bus.clear = (wr_done && reg_index == event_irq_pkg::IDX_EVENT_FLAGS)
    ? pwdata[event_irq_pkg::FLAG_WIDTH-1:0] : '0;

  // ----------------------------------------------------------------------
  // Alert pin
  // ----------------------------------------------------------------------
  logic next_alert;

  assign next_alert = interrupt_config[event_irq_pkg::POS_ALERT_ENABLE]
    && |(event_mask[event_irq_pkg::FLAG_WIDTH-1:0] & flag_bus.flags);

  // Open drain: the pin only ever sinks, so its data stays low
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      alert_n_out <= 1'b0;
      alert_n_oe  <= 1'b0;
    end else begin
      alert_n_out <= 1'b0;
      alert_n_oe  <= next_alert;
    end
  end

  // ----------------------------------------------------------------------
  // System interrupt
  // ----------------------------------------------------------------------
  logic [event_irq_pkg::SYS_WIDTH-1:0] sys_event;
  logic [event_irq_pkg::SYS_WIDTH-1:0] sys_clear;

  assign sys_event[event_irq_pkg::POS_SYS_ALERT_RISE] = next_alert && !alert_n_oe;
  assign sys_event[event_irq_pkg::POS_SYS_OVERRUN]    = |flag_bus.overrun;
  assign sys_clear = (wr_done && reg_index == event_irq_pkg::IDX_SYS_CLEAR)
    ? pwdata[event_irq_pkg::SYS_WIDTH-1:0] : '0;

  // Event in the clearing cycle wins so it is not lost
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sys_status <= event_irq_pkg::RESET_SYS;
    end else begin
      sys_status <= (sys_status & ~sys_clear) | sys_event;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sys_enable <= event_irq_pkg::RESET_SYS;
    end else if (wr_done && reg_index == event_irq_pkg::IDX_SYS_ENABLE) begin
      sys_enable <= pwdata[event_irq_pkg::SYS_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((sys_status & ~sys_clear | sys_event) & sys_enable);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_flag_write;
    wr_done && reg_index == event_irq_pkg::IDX_EVENT_FLAGS;
  endsequence

  sequence s_prox_one_sample;
    prox_one_done && prox_one_mask && mode_prox_one == 2'h0;
  endsequence

  a_alert_disabled: assert property (@(posedge clk) disable iff (!reset_n)
    !interrupt_config[0] |=> !alert_n_oe)
    else $error("alert pin driven with output enable clear");

  a_alert_follows: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> alert_n_oe == ($past(interrupt_config[0])
      && |($past(event_mask[4:0]) & $past(flag_bus.flags))))
    else $error("alert pin does not follow masked flags");

  a_alert_drops: assert property (@(posedge clk) disable iff (!reset_n)
    (event_mask[4:0] & flag_bus.flags) == 5'h00 |=> !alert_n_oe)
    else $error("alert pin held with no masked flag");

  a_pin_sinks: assert property (@(posedge clk) disable iff (!reset_n)
    alert_n_oe |-> alert_n_out == 1'b0)
    else $error("alert pin driven high");

  a_clear_by_one: assert property (@(posedge clk) disable iff (!reset_n)
    s_flag_write ##0 (pwdata[2] && !next_set[2]) |=> !flag_bus.flags[2])
    else $error("flag written as one did not clear");

  a_prox_one_set: assert property (@(posedge clk) disable iff (!reset_n)
    s_prox_one_sample |=> flag_bus.flags[2])
    else $error("channel one sample did not set its flag");

  a_prox_two_gate: assert property (@(posedge clk) disable iff (!reset_n)
    (!prox_two_mask && !flag_bus.flags[3]) |=> !flag_bus.flags[3])
    else $error("masked channel two raised a flag");

  a_prox_three_set: assert property (@(posedge clk) disable iff (!reset_n)
    (prox_three_done && prox_three_mask && mode_prox_three == 2'h0) |=> flag_bus.flags[4])
    else $error("channel three sample did not set its flag");

  a_ambient_set: assert property (@(posedge clk) disable iff (!reset_n)
    (ambient_done && ambient_mask == 2'h1 && mode_ambient == 2'h0)
      |=> flag_bus.flags[0] ##1 (flag_bus.flags[0] || $past(flag_bus.clear[0])))
    else $error("ambient sample did not set its flag");

  a_mode_blocks: assert property (@(posedge clk) disable iff (!reset_n)
    (mode_prox_one != 2'h0 && !flag_bus.flags[2]) |=> !flag_bus.flags[2])
    else $error("flag set under a threshold mode");

  a_apb_answer: assert property (@(posedge clk) disable iff (!reset_n)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("bus answer not a single cycle after setup");
endmodule

// *** event_irq_pkg.sv ***
// Constants shared by the sensor event interrupt logic
package event_irq_pkg;
  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [9:0] IDX_INTERRUPT_CONFIG = 10'h003;
  localparam logic [9:0] IDX_EVENT_MASK       = 10'h004;
  localparam logic [9:0] IDX_EVENT_MODE_A     = 10'h005;
  localparam logic [9:0] IDX_EVENT_MODE_B     = 10'h006;
  localparam logic [9:0] IDX_EVENT_FLAGS      = 10'h021;
  localparam logic [9:0] IDX_SYS_STATUS       = 10'h040;
  localparam logic [9:0] IDX_SYS_CLEAR        = 10'h041;
  localparam logic [9:0] IDX_SYS_ENABLE       = 10'h042;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned FLAG_WIDTH         = 5;
  localparam int unsigned POS_ALERT_ENABLE   = 0;
  localparam int unsigned POS_AMBIENT_LO     = 0;
  localparam int unsigned POS_AMBIENT_HI     = 1;
  localparam int unsigned POS_PROX_ONE       = 2;
  localparam int unsigned POS_PROX_TWO       = 3;
  localparam int unsigned POS_PROX_THREE     = 4;
  localparam int unsigned POS_MODE_AMBIENT   = 0;
  localparam int unsigned POS_MODE_PROX_ONE  = 4;
  localparam int unsigned POS_MODE_PROX_TWO  = 6;
  localparam int unsigned POS_MODE_PROX_THREE = 0;
  localparam int unsigned SYS_WIDTH          = 2;
  localparam int unsigned POS_SYS_ALERT_RISE = 0;
  localparam int unsigned POS_SYS_OVERRUN    = 1;

  // ----------------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] AMBIENT_EVERY_SAMPLE = 2'h1;
  localparam logic [1:0] MODE_EVERY_SAMPLE    = 2'h0;
  localparam logic [7:0] RESET_REG8           = 8'h00;
  localparam logic [4:0] RESET_FLAGS          = 5'h00;
  localparam logic [1:0] RESET_SYS            = 2'h0;
endpackage

// *** flag_bank_if.sv ***
// Set, clear and state of a bank of sticky flags
`timescale 1ns/1ps
interface flag_bank_if #(parameter int unsigned WIDTH = 5);
  logic [WIDTH-1:0] set;
  logic [WIDTH-1:0] clear;
  logic [WIDTH-1:0] flags;
  logic [WIDTH-1:0] overrun;

  modport bank (input set, input clear, output flags, output overrun);
  modport user (output set, output clear, input flags, input overrun);
endinterface

// *** sticky_flag_bank.sv ***
// Bank of sticky flags, hardware set beats software clear
`timescale 1ns/1ps
module sticky_flag_bank #(
  parameter int unsigned      WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic clk,
  input  wire logic reset_n,
  flag_bank_if.bank port
);
  // ----------------------------------------------------------------------
  // Flag state
  // ----------------------------------------------------------------------
  logic [WIDTH-1:0] next_flags;

  // Clear only what was written as one; a same-cycle set survives
  assign next_flags = (port.flags & ~port.clear) | port.set;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port.flags <= RESET_VALUE;
    end else begin
      port.flags <= next_flags;
    end
  end

  // A set landing on an already pending flag
  assign port.overrun = port.set & port.flags;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_set_wins_clear: assert property (@(posedge clk) disable iff (!reset_n)
    |(port.set & port.clear) |=> ((port.flags & $past(port.set)) == $past(port.set)))
    else $error("flag set lost to a clear in the same cycle");

  a_flag_holds: assert property (@(posedge clk) disable iff (!reset_n)
    (port.clear == '0 && port.set == '0) |=> port.flags == $past(port.flags))
    else $error("flag changed with no set and no clear");
endmodule

// *** host_model.sv ***
// Host processor model: APB master that services the open-drain alert line
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk,
  input  wire logic        alert_pin,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // Request held until pready is seen high at a rising edge
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'h0};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~wd;
  endtask

  // Writing back the copy clears only the sources that were seen
  task automatic service(input int slow, output logic [31:0] seen);
    logic        err;
    logic [31:0] junk;
    repeat (slow) @(posedge clk);
    seen = 32'h0000_0000;
    if (alert_pin === 1'b0) begin
      xfer(1'b0, event_irq_pkg::IDX_EVENT_FLAGS, 32'h0000_0000, seen, err);
      xfer(1'b1, event_irq_pkg::IDX_EVENT_FLAGS, seen, junk, err);
    end
  endtask
endmodule

// *** sensor_event_interrupt_logic_tb.sv ***
// Self-checking bench for the sensor event interrupt logic
`timescale 1ns/1ps
module sensor_event_interrupt_logic_tb;
  logic        clk;
  logic        reset_n;
  logic [4:0]  ev;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        alert_n_out;
  logic        alert_n_oe;
  logic        irq;
  logic        alert_pin;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch;
  int          total_checks;
  int          cycles;

  // Pull-up on the open-drain pin
  assign alert_pin = (alert_n_oe === 1'b1) ? alert_n_out : 1'b1;

  sensor_event_interrupt_logic i_dut (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prox_one_done(ev[2]), .prox_two_done(ev[3]), .prox_three_done(ev[4]),
    .ambient_done(ev[0]), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe), .irq(irq)
  );

  host_model i_host (
    .clk(clk), .alert_pin(alert_pin), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  initial clk = 1'b0;
  always #20 clk = ~clk;

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    i_host.xfer(1'b1, idx, d, rd, err);
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
    i_host.xfer(1'b0, idx, 32'h0000_0000, rd, err);
    check(rd, exp);
  endtask

  task automatic pulse(input logic [4:0] bits);
    @(posedge clk);
    ev <= bits;
    @(posedge clk);
    ev <= 5'h00;
    repeat (3) @(posedge clk);
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic reset_values;
    logic [9:0] idx [7] = '{event_irq_pkg::IDX_INTERRUPT_CONFIG, event_irq_pkg::IDX_EVENT_MASK,
      event_irq_pkg::IDX_EVENT_MODE_A, event_irq_pkg::IDX_EVENT_MODE_B,
      event_irq_pkg::IDX_EVENT_FLAGS, event_irq_pkg::IDX_SYS_STATUS,
      event_irq_pkg::IDX_SYS_ENABLE};
    check1(alert_n_oe, 1'b0);
    check1(irq, 1'b0);
    foreach (idx[i]) rdc(idx[i], 32'h0000_0000);
  endtask

  task automatic register_access;
    wr(event_irq_pkg::IDX_INTERRUPT_CONFIG, 32'h0000_0001);
    rdc(event_irq_pkg::IDX_INTERRUPT_CONFIG, 32'h0000_0001);
    check1(err, 1'b0);
    wr(event_irq_pkg::IDX_EVENT_MODE_B, 32'h0000_0003);
    rdc(event_irq_pkg::IDX_EVENT_MODE_B, 32'h0000_0003);
    wr(event_irq_pkg::IDX_EVENT_MODE_B, 32'h0000_0000);
    i_host.xfer(1'b0, 10'h3ff, 32'h0000_0000, rd, err);
    check1(err, 1'b1);
    check(rd, 32'h0000_0000);
  endtask

  task automatic channel_gating;
    logic [4:0]  bits [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
    logic [31:0] seen;
    foreach (bits[i]) begin
      wr(event_irq_pkg::IDX_EVENT_MASK, 32'h0000_0000);
      pulse(bits[i]);
      rdc(event_irq_pkg::IDX_EVENT_FLAGS, 32'h0000_0000);
      check1(alert_pin, 1'b1);
      wr(event_irq_pkg::IDX_EVENT_MASK, {27'h0, bits[i]});
      pulse(bits[i]);
      rdc(event_irq_pkg::IDX_EVENT_FLAGS, {27'h0, bits[i]});
      check1(alert_pin, 1'b0);
      i_host.service((i % 2) * 5, seen);
      check(seen, {27'h0, bits[i]});
      settle;
      check1(alert_pin, 1'b1);
    end
    wr(event_irq_pkg::IDX_EVENT_MASK, 32'h0000_0002);
    pulse(5'h01);
    rdc(event_irq_pkg::IDX_EVENT_FLAGS, 32'h0000_0000);
  endtask

  task automatic output_enable;
    wr(event_irq_pkg::IDX_INTERRUPT_CONFIG, 32'h0000_0000);
    wr(event_irq_pkg::IDX_EVENT_MASK, 32'h0000_0004);
    pulse(5'h04);
    check1(alert_n_oe, 1'b0);
    wr(event_irq_pkg::IDX_INTERRUPT_CONFIG, 32'h0000_0001);
    settle;
    check1(alert_n_oe, 1'b1);
    check1(alert_n_out, 1'b0);
    wr(event_irq_pkg::IDX_EVENT_MASK, 32'h0000_0000);
    settle;
    check1(alert_n_oe, 1'b0);
    rdc(event_irq_pkg::IDX_EVENT_FLAGS, 32'h0000_0004);
    wr(event_irq_pkg::IDX_EVENT_FLAGS, 32'h0000_001f);
  endtask

  task automatic write_one_clear;
    wr(event_irq_pkg::IDX_EVENT_MASK, 32'h0000_001c);
    pulse(5'h1c);
    wr(event_irq_pkg::IDX_EVENT_FLAGS, 32'h0000_0000);
    rdc(event_irq_pkg::IDX_EVENT_FLAGS, 32'h0000_001c);
    wr(event_irq_pkg::IDX_EVENT_FLAGS, 32'h0000_0008);
    rdc(event_irq_pkg::IDX_EVENT_FLAGS, 32'h0000_0014);
    check1(alert_n_oe, 1'b1);
    wr(event_irq_pkg::IDX_EVENT_FLAGS, 32'h0000_0014);
    settle;
    check1(alert_n_oe, 1'b0);
  endtask

  task automatic set_beats_clear;
    wr(event_irq_pkg::IDX_EVENT_MASK, 32'h0000_0004);
    pulse(5'h04);
    fork
      wr(event_irq_pkg::IDX_EVENT_FLAGS, 32'h0000_0004);
      begin
        repeat (2) @(posedge clk);
        ev <= 5'h04;
        @(posedge clk);
        ev <= 5'h00;
      end
    join
    rdc(event_irq_pkg::IDX_EVENT_FLAGS, 32'h0000_0004);
    wr(event_irq_pkg::IDX_EVENT_FLAGS, 32'h0000_0004);
  endtask

  // Every mode field non-zero at once, then all back to every-sample
  task automatic mode_refusal;
    wr(event_irq_pkg::IDX_EVENT_MASK, 32'h0000_001d);
    wr(event_irq_pkg::IDX_EVENT_MODE_A, 32'h0000_0051);
    wr(event_irq_pkg::IDX_EVENT_MODE_B, 32'h0000_0002);
    pulse(5'h1d);
    rdc(event_irq_pkg::IDX_EVENT_FLAGS, 32'h0000_0000);
    wr(event_irq_pkg::IDX_EVENT_MODE_A, 32'h0000_0000);
    wr(event_irq_pkg::IDX_EVENT_MODE_B, 32'h0000_0000);
    pulse(5'h1d);
    rdc(event_irq_pkg::IDX_EVENT_FLAGS, 32'h0000_001d);
    wr(event_irq_pkg::IDX_EVENT_FLAGS, 32'h0000_001d);
  endtask

  // Alert rise and overrun land in the system status; irq follows enable
  task automatic system_irq;
    wr(event_irq_pkg::IDX_SYS_CLEAR, 32'h0000_0003);
    wr(event_irq_pkg::IDX_SYS_ENABLE, 32'h0000_0001);
    pulse(5'h04);
    check1(irq, 1'b1);
    pulse(5'h04);
    rdc(event_irq_pkg::IDX_SYS_STATUS, 32'h0000_0003);
    wr(event_irq_pkg::IDX_SYS_ENABLE, 32'h0000_0000);
    wr(event_irq_pkg::IDX_SYS_STATUS, 32'h0000_0000);
    settle;
    check1(irq, 1'b0);
    rdc(event_irq_pkg::IDX_SYS_STATUS, 32'h0000_0003);
    rdc(event_irq_pkg::IDX_SYS_CLEAR, 32'h0000_0000);
    wr(event_irq_pkg::IDX_SYS_ENABLE, 32'h0000_0002);
    settle;
    check1(irq, 1'b1);
    wr(event_irq_pkg::IDX_SYS_CLEAR, 32'h0000_0002);
    settle;
    check1(irq, 1'b0);
    rdc(event_irq_pkg::IDX_SYS_STATUS, 32'h0000_0001);
  endtask

  // Hang guard, generous against the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize;
    end
  end

  initial begin
    reset_n = 1'b0;
    ev = 5'h00;
    n_mismatch = 0;
    total_checks = 0;
    cycles = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    reset_values;
    register_access;
    channel_gating;
    output_enable;
    write_one_clear;
    set_beats_clear;
    mode_refusal;
    system_irq;
    summarize;
  end
endmodule
